// ===== design/dom_pkg.sv
package dom_pkg;

    // Register byte offsets
    localparam logic [7:0] DOM_OFF_CFG   = 8'h00;
    localparam logic [7:0] DOM_OFF_SRC   = 8'h04;
    localparam logic [7:0] DOM_OFF_COAST = 8'h08;
    localparam logic [7:0] DOM_OFF_CMD   = 8'h0C;
    localparam logic [7:0] DOM_OFF_STAT  = 8'h10;

    // Field positions
    localparam int DOM_CFG_START_LSB = 0;
    localparam int DOM_CFG_MSEL_LSB  = 4;
    localparam int DOM_CMD_TGT_LSB   = 0;
    localparam int DOM_CMD_REQ_BIT   = 2;
    localparam int DOM_CMD_RST_BIT   = 3;
    localparam int DOM_STAT_REF_BIT  = 5;

    // Reset values
    localparam logic [3:0]  DOM_RST_START = 4'h0;
    localparam logic [2:0]  DOM_RST_MSEL  = 3'h0;
    localparam logic [13:0] DOM_RST_SRC   = 14'h270F;
    localparam logic [13:0] DOM_RST_COAST = 14'h270F;

    // Setting codes
    localparam logic [3:0]  DOM_START_BUS1 = 4'h1;
    localparam logic [3:0]  DOM_START_BUS2 = 4'h2;
    localparam logic [3:0]  DOM_START_PB10 = 4'hA;
    localparam logic [3:0]  DOM_START_PB12 = 4'hC;
    localparam logic [13:0] DOM_SRC_OPT    = 14'h0000;
    localparam logic [13:0] DOM_SRC_SER    = 14'h0001;
    localparam logic [13:0] DOM_SRC_AUTO   = 14'h270F;
    localparam logic [13:0] DOM_COAST_OFF  = 14'h270F;

    // Bus responses
    localparam logic [1:0] DOM_RESP_OKAY   = 2'h0;
    localparam logic [1:0] DOM_RESP_SLVERR = 2'h2;

    // Operation modes
    typedef enum logic [1:0] {
        DOM_TERM  = 2'b00,
        DOM_PANEL = 2'b01,
        DOM_BUS   = 2'b10,
        DOM_COMB  = 2'b11
    } dom_mode_t;

    // Switching permissions and startup mode
    typedef struct packed {
        logic      tp;
        logic      tb;
        logic      pb;
        logic      run_ok;
        dom_mode_t start;
    } dom_perm_t;

    // Startup mode and allowed changes from the settings
    function automatic dom_perm_t dom_perm_f(input logic [3:0] st,
                                             input logic [2:0] ms,
                                             input logic       ilk);
        dom_perm_t p;
        logic      bus_st;
        logic      pb_st;
        p      = '0;
        bus_st = (st == DOM_START_BUS1) || (st == DOM_START_BUS2);
        pb_st  = (st == DOM_START_PB10) || (st == DOM_START_PB12);
        p.start = DOM_TERM;
        case (ms)
            3'h0:
            begin
                p.start = (bus_st || pb_st) ? DOM_BUS : DOM_TERM;
                p.pb    = pb_st;
                p.tp    = !pb_st;
                p.tb    = !pb_st;
            end
            3'h1:       p.start = DOM_PANEL;
            3'h2:
            begin
                p.start = (bus_st || pb_st) ? DOM_BUS : DOM_TERM;
                p.tb    = !pb_st;
            end
            3'h3, 3'h4: p.start = DOM_COMB;
            3'h6:
            begin
                p.start  = (bus_st || pb_st) ? DOM_BUS : DOM_TERM;
                p.pb     = pb_st;
                p.tp     = !pb_st;
                p.tb     = !pb_st;
                p.run_ok = 1'b1;
            end
            3'h7:
            begin
                p.start = (bus_st && ilk) ? DOM_BUS : DOM_TERM;
                p.tp    = ilk;
                p.tb    = ilk;
            end
            default:    p.start = DOM_TERM;
        endcase
        return p;
    endfunction

endpackage

// ===== design/dom_sync.sv
`timescale 1ns/10ps
`default_nettype none

module dom_sync
    import dom_pkg::*;
#(
    parameter int W = 1
)
(
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    // Pins in and synchronised out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta;   // First stage, read only by the second

    // Two flip-flop synchroniser
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta     <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

`default_nettype wire

// ===== design/dom_mode_ctrl.sv
// Functional notes
// - Startup setting 1, 2, 10 or 12 allows bus startup
// - Network parameter writes after bus startup
// - Startup setting applies at next reset
// - Setting 0, selection 0: terminal, all switch
// - Selection 1: panel mode, fixed
// - Selection 2: terminal/bus only, panel refused
// - Selection 3/4: combined mode, no changes
// - Selection 6: all modes, even running
// - Selection 7: interlock off forces terminal
// - Setting 1/2: bus startup, same switching
// - Setting 10/12, selection 0: panel/bus only
// - Setting 10/12, selection 2: bus fixed
// - Setting 10/12, selection 6: panel/bus running
// - Setting 10/12, selection 7: terminal start
// - No direct panel to bus change, except with setting 10/12
// - Panel key or switch input changes
// - Resume state after brief outage
// - Control source picks option or serial
`timescale 1ns/10ps
`default_nettype none

module dom_mode_ctrl
    import dom_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    // AXI4-Lite write channels
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Drive pins
    input  wire logic              panel_interlock_input,
    input  wire logic              panel_bus_switch_input,
    input  wire logic              panel_key,
    input  wire logic              forward_start_input,
    input  wire logic              reverse_start_input,
    input  wire logic              motor_running,
    input  wire logic              option_mounted,
    input  wire logic              power_restored,
    // Mode and source outputs
    output dom_mode_t              op_mode,
    output logic                   param_write_en,
    output logic                   option_port_valid,
    output logic                   serial_port_valid
);

    // Synchronised pins
    logic [7:0] pins_s;
    logic       ilk, pbsw, key, fwd, rev, run, opt, rest;
    assign {ilk, pbsw, key, fwd, rev, run, opt, rest} = pins_s;

    dom_sync #(.W(8)) u_sync (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .async_in ({panel_interlock_input, panel_bus_switch_input, panel_key,
                    forward_start_input, reverse_start_input, motor_running,
                    option_mounted, power_restored}),
        .sync_out (pins_s)
    );

    // Software settings
    logic [3:0]  cfg_start;     // Startup mode setting
    logic [2:0]  cfg_msel;      // Mode selection setting
    logic [13:0] cfg_src;       // Bus control source setting
    logic [13:0] cfg_coast;     // Restart coasting time
    // Settings in force since the last start
    logic [3:0]  lat_start;
    logic [2:0]  lat_msel;
    logic [13:0] lat_src;
    // Control state
    logic        booted;        // Startup done since reset
    logic        boot_in_bus;   // Last start came up in bus mode
    logic        refused;       // Sticky refused request
    logic        key_d, pbsw_d, rest_d;
    logic        sw_req;        // Software change request pulse
    dom_mode_t   sw_tgt;
    logic        soft_rst;      // Drive reset pulse
    // Bus slave state
    logic              aw_hold, w_hold;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              wr_go;
    logic              wr_hit;
    logic [31:0]       rd_val;
    logic              rd_hit;

    // Permissions now and at a fresh start
    dom_perm_t perm, boot_perm;
    assign perm      = dom_perm_f(lat_start, lat_msel, ilk);
    assign boot_perm = dom_perm_f(cfg_start, cfg_msel, ilk);

    // Byte lane merge
    function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[8*i +: 8] = new_v[8*i +: 8];
        end
        return r;
    endfunction

    // Whether a change between two modes is allowed now
    function automatic logic change_ok(input dom_mode_t cur, input dom_mode_t tgt,
                                       input dom_perm_t p, input logic stopped);
        logic pair;
        pair = ((cur == DOM_TERM  && tgt == DOM_PANEL) || (cur == DOM_PANEL && tgt == DOM_TERM))
                   ? p.tp : 1'b0;
        if ((cur == DOM_TERM && tgt == DOM_BUS) || (cur == DOM_BUS && tgt == DOM_TERM))
            pair = p.tb;
        if ((cur == DOM_PANEL && tgt == DOM_BUS) || (cur == DOM_BUS && tgt == DOM_PANEL))
            pair = p.pb;
        return pair && (p.run_ok || stopped);
    endfunction

    // Start and change events
    logic      boot_go, restore_go, recompute, force_term;
    logic      key_ev, pbsw_ev, req_any, req_legal;
    dom_mode_t req_tgt;
    assign boot_go    = !booted || soft_rst;
    assign restore_go = booted && rest && !rest_d;
    assign recompute  = boot_go || (restore_go && cfg_coast == DOM_COAST_OFF);
    assign force_term = booted && lat_msel == 3'h7 && !ilk;
    assign key_ev     = key && !key_d;
    assign pbsw_ev    = perm.pb && (pbsw != pbsw_d);

    // Request source priority: software, key, switch input
    always_comb
    begin
        req_any = 1'b1;
        if (sw_req)
            req_tgt = sw_tgt;
        else if (key_ev)
            req_tgt = (op_mode == DOM_PANEL) ? (perm.pb ? DOM_BUS : DOM_TERM)
                                             : DOM_PANEL;
        else if (pbsw_ev)
            req_tgt = pbsw ? DOM_PANEL : DOM_BUS;
        else
        begin
            req_tgt = op_mode;
            req_any = 1'b0;
        end
        req_legal = change_ok(op_mode, req_tgt, perm, !run && !fwd && !rev);
    end

    // Pin edge history
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            key_d  <= 1'b0;
            pbsw_d <= 1'b0;
            rest_d <= 1'b0;
        end
        else
        begin
            key_d  <= key;
            pbsw_d <= pbsw;
            rest_d <= rest;
        end
    end

    // Operation mode register
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            op_mode     <= DOM_TERM;
            booted      <= 1'b0;
            boot_in_bus <= 1'b0;
            lat_start   <= DOM_RST_START;
            lat_msel    <= DOM_RST_MSEL;
            lat_src     <= DOM_RST_SRC;
        end
        else if (recompute)
        begin
            // Fresh start from captured settings
            op_mode     <= boot_perm.start;
            boot_in_bus <= boot_perm.start == DOM_BUS;
            booted      <= 1'b1;
            lat_start   <= cfg_start;
            lat_msel    <= cfg_msel;
            lat_src     <= cfg_src;
        end
        else if (restore_go)
            op_mode <= op_mode;                          // Resume prior state
        else if (force_term)
            op_mode <= DOM_TERM;
        else if (req_any && req_legal)
            op_mode <= req_tgt;
    end

    // Sticky refusal flag, set wins over clear
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            refused <= 1'b0;
        else if (req_any && !req_legal && !recompute && !force_term && req_tgt != op_mode)
            refused <= 1'b1;
        else if (wr_go && aw_addr == DOM_OFF_STAT[ADDR_W-1:0] && w_strb[0]
                 && w_data[DOM_STAT_REF_BIT])
            refused <= 1'b0;
    end

    // Derived outputs
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            param_write_en    <= 1'b0;
            option_port_valid <= 1'b0;
            serial_port_valid <= 1'b0;
        end
        else
        begin
            param_write_en    <= boot_in_bus && op_mode == DOM_BUS;
            option_port_valid <= lat_src == DOM_SRC_OPT
                                 || (lat_src == DOM_SRC_AUTO && opt);
            serial_port_valid <= lat_src == DOM_SRC_SER
                                 || (lat_src == DOM_SRC_AUTO && !opt);
        end
    end

    // Write address and data capture, either order
    assign wr_go = aw_hold && w_hold && !s_axi_bvalid;
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            aw_hold       <= 1'b0;
            w_hold        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= DOM_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? DOM_RESP_OKAY : DOM_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                aw_hold       <= 1'b0;
                w_hold        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Write decode
    always_comb
    begin
        unique case (aw_addr)
            DOM_OFF_CFG[ADDR_W-1:0], DOM_OFF_SRC[ADDR_W-1:0], DOM_OFF_COAST[ADDR_W-1:0],
            DOM_OFF_CMD[ADDR_W-1:0], DOM_OFF_STAT[ADDR_W-1:0]: wr_hit = 1'b1;
            default:                                           wr_hit = 1'b0;
        endcase
    end

    // Stored words merged with write data under the byte strobes
    logic [31:0] cfg_wr;        // Configuration word after merge
    logic [31:0] src_wr;        // Source word after merge
    logic [31:0] coast_wr;      // Coasting word after merge
    assign cfg_wr   = strb_merge({25'h0, cfg_msel, cfg_start}, w_data, w_strb);
    assign src_wr   = strb_merge({18'h0, cfg_src}, w_data, w_strb);
    assign coast_wr = strb_merge({18'h0, cfg_coast}, w_data, w_strb);

    // Setting registers, writable in any mode
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cfg_start <= DOM_RST_START;
            cfg_msel  <= DOM_RST_MSEL;
            cfg_src   <= DOM_RST_SRC;
            cfg_coast <= DOM_RST_COAST;
        end
        else if (wr_go)
        begin
            if (aw_addr == DOM_OFF_CFG[ADDR_W-1:0])
            begin
                cfg_start <= cfg_wr[DOM_CFG_START_LSB +: 4];
                cfg_msel  <= cfg_wr[DOM_CFG_MSEL_LSB +: 3];
            end
            if (aw_addr == DOM_OFF_SRC[ADDR_W-1:0])
                cfg_src <= src_wr[13:0];
            if (aw_addr == DOM_OFF_COAST[ADDR_W-1:0])
                cfg_coast <= coast_wr[13:0];
        end
    end

    // Command pulses
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sw_req   <= 1'b0;
            sw_tgt   <= DOM_TERM;
            soft_rst <= 1'b0;
        end
        else
        begin
            sw_req   <= wr_go && aw_addr == DOM_OFF_CMD[ADDR_W-1:0] && w_strb[0]
                        && w_data[DOM_CMD_REQ_BIT];
            soft_rst <= wr_go && aw_addr == DOM_OFF_CMD[ADDR_W-1:0] && w_strb[0]
                        && w_data[DOM_CMD_RST_BIT];
            if (wr_go && aw_addr == DOM_OFF_CMD[ADDR_W-1:0] && w_strb[0])
                sw_tgt <= dom_mode_t'(w_data[DOM_CMD_TGT_LSB +: 2]);
        end
    end

    // Read decode
    always_comb
    begin
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            DOM_OFF_CFG[ADDR_W-1:0]:   rd_val = {25'h0, cfg_msel, cfg_start};
            DOM_OFF_SRC[ADDR_W-1:0]:   rd_val = {18'h0, cfg_src};
            DOM_OFF_COAST[ADDR_W-1:0]: rd_val = {18'h0, cfg_coast};
            DOM_OFF_CMD[ADDR_W-1:0]:   rd_val = 32'h0000_0000;
            DOM_OFF_STAT[ADDR_W-1:0]:  rd_val = {20'h0, perm.tp, perm.tb, perm.pb, perm.run_ok,
                                                1'b0, boot_in_bus, refused, serial_port_valid,
                                                option_port_valid, param_write_en, op_mode};
            default:
            begin
                rd_val = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read channel
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= DOM_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_val;
            s_axi_rresp   <= rd_hit ? DOM_RESP_OKAY : DOM_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_param_write_bus: assert property (param_write_en |-> $past(op_mode) == DOM_BUS)
        else $error("param write enabled outside bus mode");
    a_panel_fixed_mode: assert property (booted && lat_msel == 3'h1
                                         |-> op_mode == DOM_PANEL)
        else $error("panel mode not held");
    a_comb_fixed_mode: assert property (booted && (lat_msel == 3'h3 || lat_msel == 3'h4)
                                        |-> op_mode == DOM_COMB)
        else $error("combined mode not held");
    a_start_mode_load: assert property (recompute
                                        |=> op_mode == $past(boot_perm.start))
        else $error("startup mode wrong");
    a_forced_terminal: assert property (force_term && !recompute |=> op_mode == DOM_TERM)
        else $error("interlock off did not force terminal");
    a_no_panel_bus: assert property ($past(booted) && !$past(recompute)
                                     && !$past(perm.pb)
                                     |-> !($past(op_mode) == DOM_PANEL && op_mode == DOM_BUS)
                                         && !($past(op_mode) == DOM_BUS && op_mode == DOM_PANEL))
        else $error("direct panel bus change");
    a_refuse_hold: assert property (booted && req_any && !req_legal
                                    && !recompute && !restore_go && !force_term
                                    |=> $stable(op_mode))
        else $error("refused request changed mode");
    a_restore_keep: assert property (restore_go && !soft_rst
                                     && cfg_coast != DOM_COAST_OFF |=> $stable(op_mode))
        else $error("mode lost on power restore");
    a_src_option: assert property (booted && $past(lat_src) == DOM_SRC_OPT
                                   |-> option_port_valid && !serial_port_valid)
        else $error("option source not selected");
    a_refuse_flag: assert property (req_any && !req_legal && !recompute && !force_term
                                    && req_tgt != op_mode |=> refused)
        else $error("refusal not flagged");

    c_boot_bus: cover property (recompute ##1 op_mode == DOM_BUS);
    c_key_panel: cover property (key_ev && req_legal ##1 op_mode == DOM_PANEL);
    c_refused: cover property (booted && req_any && !req_legal ##1 refused);
    c_restore: cover property (restore_go && cfg_coast != DOM_COAST_OFF);

endmodule

`default_nettype wire

// ===== sim/dom_pins_model.sv
`timescale 1ns/10ps
`default_nettype none
module dom_pins_model
(
    // Clock
    input  wire logic clk_sys,
    // Requests from the bench
    input  wire logic key_go,
    input  wire logic pwr_go,
    // Panel key and supply monitor pins
    output logic      panel_key,
    output logic      power_restored
);
    logic [2:0] key_cnt = 3'h0; // Key press length
    logic [2:0] pwr_cnt = 3'h0; // Restore pulse length
    // Hold each pulse long enough to pass the synchroniser
    always_ff @(posedge clk_sys)
    begin
        key_cnt <= key_go ? 3'h4 : key_cnt - {2'h0, key_cnt != 3'h0};
        pwr_cnt <= pwr_go ? 3'h4 : pwr_cnt - {2'h0, pwr_cnt != 3'h0};
    end
    assign panel_key      = key_cnt != 3'h0;
    assign power_restored = pwr_cnt != 3'h0;
endmodule
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import dom_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd;
    logic panel_interlock_input = 1'b1, panel_bus_switch_input = 1'b0;
    logic motor_running = 1'b0, option_mounted = 1'b0, key_go = 1'b0, pwr_go = 1'b0;
    logic forward_start_input = 1'b0, reverse_start_input = 1'b0;
    logic panel_key, power_restored, param_write_en, option_port_valid, serial_port_valid;
    dom_mode_t op_mode;
    int err_total = 0, checks_done = 0, cyc = 0, i;
    // Rows: startup[9:6], selection[5:3], interlock[2], mode[1:0]
    logic [9:0] rows [17] = '{10'h004, 10'h00D, 10'h014, 10'h01F, 10'h027, 10'h034,
        10'h038, 10'h046, 10'h096, 10'h076, 10'h0BE, 10'h078, 10'h286, 10'h316,
        10'h2B6, 10'h33C, 10'h28D};
    dom_mode_ctrl u_dom_mode_ctrl (.clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .panel_interlock_input, .panel_bus_switch_input, .panel_key,
        .forward_start_input, .reverse_start_input, .motor_running,
        .option_mounted, .power_restored, .op_mode, .param_write_en,
        .option_port_valid, .serial_port_valid);
    dom_pins_model u_dom_pins_model (.clk_sys, .key_go, .pwr_go, .panel_key,
        .power_restored);
    always #10 clk_sys = ~clk_sys;
    // Cut a hang short
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            wrap_up();
        end
    end
    task wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Bus write, both channels offered together
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // Bus read
    task rdr(input logic [7:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task start(input logic [31:0] cfg);
        wr(DOM_OFF_CFG, cfg);
        wr(DOM_OFF_CMD, 32'h8);
        wt(6);
    endtask
    task req(input dom_mode_t m);
        wr(DOM_OFF_CMD, {29'h0, 1'b1, m});
        wt(6);
    endtask
    task src(input logic [31:0] v, input logic m, input logic [1:0] e);
        wr(DOM_OFF_SRC, v);
        option_mounted <= m;
        start(32'h0);
        chk({option_port_valid, serial_port_valid}, e);
    endtask
    task outage(input logic [31:0] c, input dom_mode_t e);
        wr(DOM_OFF_COAST, c);
        start(32'h0);
        req(DOM_PANEL);
        pwr_go <= 1'b1;
        wt(1);
        pwr_go <= 1'b0;
        wt(10);
        chk(op_mode, e);
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        wt(2);
        sys_rst <= 1'b0;
        wt(4);
        chk(op_mode, DOM_TERM);
        rdr(8'h20);
        chk(rsp, DOM_RESP_SLVERR);
        wr(8'h20, 32'h0);
        chk(rsp, DOM_RESP_SLVERR);
        for (i = 0; i < 17; i++)
        begin
            panel_interlock_input <= rows[i][2];
            start({25'h0, rows[i][5:3], rows[i][9:6]});
            chk(op_mode, rows[i][1:0]);
        end
        wr(DOM_OFF_CFG, 32'h1);
        wt(6);
        chk(op_mode, DOM_PANEL);
        chk(param_write_en, 1'b0);
        wr(DOM_OFF_CMD, 32'h8);
        wt(6);
        chk(param_write_en, 1'b1);
        start(32'h0);
        req(DOM_PANEL);
        req(DOM_BUS);
        chk(op_mode, DOM_PANEL);
        rdr(DOM_OFF_STAT);
        chk(rd[5], 1'b1);
        wr(DOM_OFF_STAT, 32'h20);
        chk(rsp, DOM_RESP_OKAY);
        rdr(DOM_OFF_STAT);
        chk(rd[5], 1'b0);
        req(DOM_TERM);
        req(DOM_BUS);
        chk(op_mode, DOM_BUS);
        forward_start_input <= 1'b1;
        req(DOM_TERM);
        chk(op_mode, DOM_BUS);
        forward_start_input <= 1'b0;
        reverse_start_input <= 1'b1;
        req(DOM_TERM);
        chk(op_mode, DOM_BUS);
        reverse_start_input <= 1'b0;
        motor_running <= 1'b1;
        req(DOM_TERM);
        chk(op_mode, DOM_BUS);
        start(32'h60);
        req(DOM_PANEL);
        chk(op_mode, DOM_PANEL);
        motor_running <= 1'b0;
        start(32'hA);
        req(DOM_TERM);
        chk(op_mode, DOM_BUS);
        panel_bus_switch_input <= 1'b1;
        wt(8);
        chk(op_mode, DOM_PANEL);
        key_go <= 1'b1;
        wt(1);
        key_go <= 1'b0;
        wt(10);
        chk(op_mode, DOM_BUS);
        panel_bus_switch_input <= 1'b0;
        src(32'h0, 1'b0, 2'h2);
        src(32'h1, 1'b1, 2'h1);
        src(32'h270F, 1'b0, 2'h1);
        src(32'h270F, 1'b1, 2'h2);
        outage(32'h5, DOM_PANEL);
        outage(32'h270F, DOM_TERM);
        sys_rst <= 1'b1;
        wt(2);
        sys_rst <= 1'b0;
        wt(4);
        rdr(DOM_OFF_SRC);
        chk(rd, 32'h270F);
        wrap_up();
    end
endmodule
`default_nettype wire
